// ---- inc/excl_lock_pkg.sv ----
// Constants and types shared by the atomic-access bus master.
// Assumes a single-beat, one-outstanding master on a burst interconnect port.
package excl_lock_pkg;

	// ----------------------------------------------------------------
	// Lock field and response encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] LOCK_NORMAL = 2'h0;
	localparam logic [1:0] LOCK_EXCL   = 2'h1;
	localparam logic [1:0] LOCK_LOCKED = 2'h2;
	localparam logic [1:0] LOCK_RSVD   = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;

	// ----------------------------------------------------------------
	// Fixed address-channel attributes
	// ----------------------------------------------------------------
	localparam logic [3:0] LEN_SINGLE    = 4'h0;
	localparam logic [1:0] BURST_INCR    = 2'h1;
	localparam logic [3:0] CACHE_NONE    = 4'h0;
	localparam logic [2:0] PROT_DEFAULT  = 3'h0;
	// Largest exclusive transfer is 2**7 = 128 bytes
	localparam logic [2:0] EXCL_SIZE_MAX = 3'h7;

	// ----------------------------------------------------------------
	// Transaction sequencer states, Gray along the read path only
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_RADDR = 3'h1,
		ST_RDATA = 3'h3,
		ST_DONE  = 3'h2,
		ST_WREQ  = 3'h6,
		ST_WRSP  = 3'h7
	} seq_state_e;

endpackage : excl_lock_pkg

// ---- rtl/chan_hold.sv ----
// Valid holder for one address or data channel.
// Assumes load is never raised while valid is still pending.
`timescale 1ns/1ps
module chan_hold (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic load,
	input  wire logic ready,
	output logic      valid
);

	logic valid_q;
	logic valid_d;

	// ----------------------------------------------------------------
	// Hold valid from load until the channel handshake
	// ----------------------------------------------------------------
	always_comb begin
		valid_d = valid_q;
		if (load) begin
			valid_d = 1'b1;
		end else if (valid_q && ready) begin
			valid_d = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= valid_d;
		end
	end

	assign valid = valid_q;

endmodule : chan_hold

// ---- rtl/excl_lock_master.sv ----
// Bus master issuing normal, exclusive and locked single-beat transactions.
// Assumes a slave with an exclusive monitor and an arbiter that honours locks.
//
// Notes on behaviour
// - Lock field: 00 normal, 01 exclusive, 10 locked; 11 never issued.
// - Exclusive write only starts after the exclusive read fully completed.
// - OKAY on exclusive read means unsupported; the exclusive write is skipped.
// - Exclusive write matches read address, size, length, controls and ID.
// - Exclusive address aligned to the transaction byte count.
// - Exclusive byte count is a power of two, at most 128.
// - Exclusive transactions carry non-cacheable attributes.
// - Arbiter grants region only to the locking master until unlock completes.
// - No transactions outstanding when a locked sequence starts.
// - Locked transaction locks the next; an unlocked one ends the sequence.
// - Earlier locked ones done before unlock; unlock done before anything new.
// - All transactions of a locked sequence carry the same ID.
// - Locked sequences preferably within one 4KB region, two transactions.
`timescale 1ns/1ps
module excl_lock_master
	import excl_lock_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int DATA_W = 32,
	parameter int ID_W   = 4
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	// User command port
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire logic                  cmd_write,
	input  wire logic [1:0]            cmd_lock,
	input  wire logic [ADDR_W-1:0]     cmd_addr,
	input  wire logic [2:0]            cmd_size,
	input  wire logic [ID_W-1:0]       cmd_id,
	input  wire logic [DATA_W-1:0]     cmd_wdata,
	output logic                       rsp_valid,
	output logic [1:0]                 rsp_resp,
	output logic [DATA_W-1:0]          rsp_rdata,
	output logic                       rsp_excl_ok,
	output logic                       rsp_refused,
	output logic                       lock_active,
	// Write address channel
	output logic [ID_W-1:0]            awid,
	output logic [ADDR_W-1:0]          awaddr,
	output logic [3:0]                 awlen,
	output logic [2:0]                 awsize,
	output logic [1:0]                 awburst,
	output logic [1:0]                 awlock,
	output logic [3:0]                 awcache,
	output logic [2:0]                 awprot,
	output logic                       awvalid,
	input  wire logic                  awready,
	// Write data channel
	output logic [ID_W-1:0]            wid,
	output logic [DATA_W-1:0]          wdata,
	output logic [DATA_W/8-1:0]        wstrb,
	output logic                       wlast,
	output logic                       wvalid,
	input  wire logic                  wready,
	// Write response channel
	input  wire logic [ID_W-1:0]       bid,
	input  wire logic [1:0]            bresp,
	input  wire logic                  bvalid,
	output logic                       bready,
	// Read address channel
	output logic [ID_W-1:0]            arid,
	output logic [ADDR_W-1:0]          araddr,
	output logic [3:0]                 arlen,
	output logic [2:0]                 arsize,
	output logic [1:0]                 arburst,
	output logic [1:0]                 arlock,
	output logic [3:0]                 arcache,
	output logic [2:0]                 arprot,
	output logic                       arvalid,
	input  wire logic                  arready,
	// Read data channel
	input  wire logic [ID_W-1:0]       rid,
	input  wire logic [DATA_W-1:0]     rdata,
	input  wire logic [1:0]            rresp,
	input  wire logic                  rlast,
	input  wire logic                  rvalid,
	output logic                       rready
);

	localparam int STRB_W = DATA_W / 8;
	localparam int OFF_W  = $clog2(STRB_W);
	localparam logic [2:0] BUS_SIZE_MAX = 3'(OFF_W);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	seq_state_e          state_q,   state_d;
	logic [ID_W-1:0]     id_q,      id_d;
	logic [ADDR_W-1:0]   addr_q,    addr_d;
	logic [2:0]          size_q,    size_d;
	logic [1:0]          lock_q,    lock_d;
	logic [DATA_W-1:0]   wdata_q,   wdata_d;
	logic [STRB_W-1:0]   strb_q,    strb_d;
	logic [1:0]          resp_q,    resp_d;
	logic [DATA_W-1:0]   rdata_q,   rdata_d;
	logic                exok_q,    exok_d;
	logic                refused_q, refused_d;
	logic                resv_q,    resv_d;
	logic                resv_ok_q, resv_ok_d;
	logic [ID_W-1:0]     resv_id_q, resv_id_d;
	logic [ADDR_W-1:0]   resv_addr_q, resv_addr_d;
	logic [2:0]          resv_size_q, resv_size_d;
	logic                held_q,    held_d;
	logic [ID_W-1:0]     held_id_q, held_id_d;

	logic                accept;
	logic [ID_W-1:0]     eff_id;
	logic [ADDR_W-1:0]   align_mask;
	logic                bad_cmd;
	logic                load_ar;
	logic                load_wr;

	assign cmd_ready = (state_q == ST_IDLE);
	assign accept    = cmd_valid && cmd_ready;
	// Inside a locked sequence every transaction reuses the locking ID
	assign eff_id     = held_q ? held_id_q : cmd_id;
	assign align_mask = ~({ADDR_W{1'b1}} << cmd_size);

	// Commands that would break the protocol are never put on the bus
	always_comb begin
		bad_cmd = (cmd_lock == LOCK_RSVD);
		if (cmd_size > BUS_SIZE_MAX) begin
			bad_cmd = 1'b1;
		end
		if (cmd_lock == LOCK_EXCL) begin
			if ((cmd_addr & align_mask) != '0) begin
				bad_cmd = 1'b1;
			end
			if (cmd_size > EXCL_SIZE_MAX) begin
				bad_cmd = 1'b1;
			end
			if (cmd_write && (!resv_q || !resv_ok_q)) begin
				bad_cmd = 1'b1;
			end
			if (cmd_write && ((cmd_addr != resv_addr_q) || (cmd_size != resv_size_q)
				|| (eff_id != resv_id_q))) begin
				bad_cmd = 1'b1;
			end
		end
	end

	assign load_ar = accept && !bad_cmd && !cmd_write;
	assign load_wr = accept && !bad_cmd && cmd_write;

	// ----------------------------------------------------------------
	// Sequencer: one transaction at a time, each fully completed
	// ----------------------------------------------------------------
	always_comb begin
		state_d     = state_q;
		id_d        = id_q;
		addr_d      = addr_q;
		size_d      = size_q;
		lock_d      = lock_q;
		wdata_d     = wdata_q;
		strb_d      = strb_q;
		resp_d      = resp_q;
		rdata_d     = rdata_q;
		exok_d      = exok_q;
		refused_d   = refused_q;
		resv_d      = resv_q;
		resv_ok_d   = resv_ok_q;
		resv_id_d   = resv_id_q;
		resv_addr_d = resv_addr_q;
		resv_size_d = resv_size_q;
		held_d      = held_q;
		held_id_d   = held_id_q;
		case (state_q)
			ST_IDLE: begin
				if (accept) begin
					id_d      = eff_id;
					addr_d    = cmd_addr;
					size_d    = cmd_size;
					lock_d    = cmd_lock;
					wdata_d   = cmd_wdata;
					strb_d    = STRB_W'(~({STRB_W{1'b1}} << (8'h1 << cmd_size))) << cmd_addr[OFF_W-1:0];
					refused_d = bad_cmd;
					resp_d    = RESP_OKAY;
					exok_d    = 1'b0;
					if (bad_cmd) begin
						state_d = ST_DONE;
					end else if (cmd_write) begin
						state_d = ST_WREQ;
					end else begin
						state_d = ST_RADDR;
					end
					if (!bad_cmd && cmd_lock == LOCK_LOCKED && !held_q) begin
						held_d    = 1'b1;
						held_id_d = cmd_id;
					end
				end
			end
			ST_RADDR: begin
				if (!arvalid) begin
					state_d = ST_RDATA;
				end
			end
			ST_RDATA: begin
				if (rvalid && rlast) begin
					rdata_d = rdata;
					resp_d  = rresp;
					exok_d  = (lock_q == LOCK_EXCL) && (rresp == RESP_EXOKAY);
					state_d = ST_DONE;
					if (lock_q == LOCK_EXCL) begin
						// A new exclusive read replaces any earlier reservation
						resv_d      = 1'b1;
						resv_ok_d   = (rresp == RESP_EXOKAY);
						resv_id_d   = id_q;
						resv_addr_d = addr_q;
						resv_size_d = size_q;
					end
				end
			end
			ST_WREQ: begin
				if (!awvalid && !wvalid) begin
					state_d = ST_WRSP;
				end
			end
			ST_WRSP: begin
				if (bvalid) begin
					resp_d  = bresp;
					exok_d  = (lock_q == LOCK_EXCL) && (bresp == RESP_EXOKAY);
					state_d = ST_DONE;
					if (lock_q == LOCK_EXCL) begin
						resv_d = 1'b0;
					end
				end
			end
			ST_DONE: begin
				// The unlocking transaction has completed before the lock drops
				if (!refused_q && lock_q != LOCK_LOCKED) begin
					held_d = 1'b0;
				end
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_q     <= ST_IDLE;
			id_q        <= '0;
			addr_q      <= '0;
			size_q      <= 3'h0;
			lock_q      <= LOCK_NORMAL;
			wdata_q     <= '0;
			strb_q      <= '0;
			resp_q      <= RESP_OKAY;
			rdata_q     <= '0;
			exok_q      <= 1'b0;
			refused_q   <= 1'b0;
			resv_q      <= 1'b0;
			resv_ok_q   <= 1'b0;
			resv_id_q   <= '0;
			resv_addr_q <= '0;
			resv_size_q <= 3'h0;
			held_q      <= 1'b0;
			held_id_q   <= '0;
		end else begin
			state_q     <= state_d;
			id_q        <= id_d;
			addr_q      <= addr_d;
			size_q      <= size_d;
			lock_q      <= lock_d;
			wdata_q     <= wdata_d;
			strb_q      <= strb_d;
			resp_q      <= resp_d;
			rdata_q     <= rdata_d;
			exok_q      <= exok_d;
			refused_q   <= refused_d;
			resv_q      <= resv_d;
			resv_ok_q   <= resv_ok_d;
			resv_id_q   <= resv_id_d;
			resv_addr_q <= resv_addr_d;
			resv_size_q <= resv_size_d;
			held_q      <= held_d;
			held_id_q   <= held_id_d;
		end
	end

	// ----------------------------------------------------------------
	// Channel valids
	// ----------------------------------------------------------------
	// Write channels are only loaded from idle, after any read completed
	chan_hold u_ar (.mclk(mclk), .resetn(resetn), .load(load_ar), .ready(arready), .valid(arvalid));
	chan_hold u_aw (.mclk(mclk), .resetn(resetn), .load(load_wr), .ready(awready), .valid(awvalid));
	chan_hold u_w  (.mclk(mclk), .resetn(resetn), .load(load_wr), .ready(wready),  .valid(wvalid));

	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	assign arid    = id_q;
	assign araddr  = addr_q;
	assign arlen   = LEN_SINGLE;
	assign arsize  = size_q;
	assign arburst = BURST_INCR;
	assign arlock  = lock_q;
	assign arcache = CACHE_NONE;
	assign arprot  = PROT_DEFAULT;
	assign awid    = id_q;
	assign awaddr  = addr_q;
	assign awlen   = LEN_SINGLE;
	assign awsize  = size_q;
	assign awburst = BURST_INCR;
	assign awlock  = lock_q;
	assign awcache = CACHE_NONE;
	assign awprot  = PROT_DEFAULT;
	assign wid     = id_q;
	assign wdata   = wdata_q;
	assign wstrb   = strb_q;
	assign wlast   = 1'b1;
	assign bready  = (state_q == ST_WRSP);
	assign rready  = (state_q == ST_RDATA);

	assign rsp_valid   = (state_q == ST_DONE);
	assign rsp_resp    = resp_q;
	assign rsp_rdata   = rdata_q;
	assign rsp_excl_ok = exok_q;
	assign rsp_refused = refused_q;
	assign lock_active = held_q;

endmodule : excl_lock_master

// ---- testbench/slave_model.sv ----
// Behavioural exclusive-capable slave with one monitor entry per ID.
// Assumes single-beat word accesses, one transaction outstanding.
`timescale 1ns/1ps
module slave_model
	import excl_lock_pkg::*;
(
	input  wire logic        mclk, resetn, excl_en, stall,
	input  wire logic [3:0]  awid, arid,
	input  wire logic [31:0] awaddr, araddr, wdata,
	input  wire logic [1:0]  awlock, arlock,
	input  wire logic        awvalid, wvalid, bready, arvalid, rready,
	output logic             awready, wready, arready,
	output logic             bvalid, rvalid,
	output logic [1:0]       bresp, rresp,
	output logic [31:0]      rdata
);
	logic [31:0] mem_q [16];
	logic [29:0] ma_q [16];
	logic [15:0] mv_q;
	logic [31:0] rd_q;
	logic        hit;

	assign awready = !stall;
	assign wready  = !stall;
	assign arready = !stall;
	// Released data bus shows no stale value
	assign rdata = rvalid ? rd_q : ~rd_q;
	assign hit = mv_q[awid] && ma_q[awid] == awaddr[31:2];

	always @(posedge mclk) begin
		if (!resetn) begin
			mv_q <= '0;
			rvalid <= 1'b0;
			bvalid <= 1'b0;
		end else begin
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (arvalid && arready) begin
				rd_q <= mem_q[araddr[5:2]];
				rvalid <= 1'b1;
				rresp <= RESP_OKAY;
				if (arlock == LOCK_EXCL && excl_en) begin
					mv_q[arid] <= 1'b1;
					ma_q[arid] <= araddr[31:2];
					rresp <= RESP_EXOKAY;
				end
			end
			if (awvalid && awready && wvalid) begin
				bvalid <= 1'b1;
				bresp <= RESP_OKAY;
				for (int i = 0; i < 16; i++)
					if (ma_q[i] == awaddr[31:2])
						mv_q[i] <= 1'b0;
				if (awlock != LOCK_EXCL || !excl_en || hit)
					mem_q[awaddr[5:2]] <= wdata;
				if (awlock == LOCK_EXCL && excl_en && hit)
					bresp <= RESP_EXOKAY;
			end
		end
	end
endmodule : slave_model

// ---- testbench/lock_chk.sv ----
// Protocol checker for the atomic-access master's bus side.
// Assumes binding into excl_lock_master; single clock domain.
`timescale 1ns/1ps
module lock_chk
	import excl_lock_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int ID_W   = 4
) (
	input wire logic              mclk, resetn, cmd_valid, cmd_ready,
	input wire logic              rsp_valid, rsp_refused, rsp_excl_ok, lock_active,
	input wire logic              awvalid, awready, wvalid, wlast, bready,
	input wire logic              arvalid, arready, rvalid, rready,
	input wire logic [1:0]        cmd_lock, awlock, arlock, rresp,
	input wire logic [2:0]        awsize, arsize,
	input wire logic [3:0]        awcache, arcache, awlen, arlen,
	input wire logic [ID_W-1:0]   awid, arid,
	input wire logic [ADDR_W-1:0] awaddr, araddr
);
	logic [ADDR_W-1:0] ra_q;
	logic [ID_W-1:0]   ri_q, li_q;
	logic [2:0]        rs_q;
	logic              rx_q, ok_q, ls_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// Reservation and lock-ID tracking
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rx_q <= 1'b0;
			ok_q <= 1'b0;
			ls_q <= 1'b0;
		end else begin
			if (arvalid && arready) begin
				rx_q <= arlock == LOCK_EXCL;
				if (arlock == LOCK_EXCL) begin
					ra_q <= araddr;
					ri_q <= arid;
					rs_q <= arsize;
				end
			end
			if (rvalid && rready && rx_q)
				ok_q <= rresp == RESP_EXOKAY;
			else if (awvalid && awready && awlock == LOCK_EXCL)
				ok_q <= 1'b0;
			if (!lock_active)
				ls_q <= 1'b0;
			else if ((arvalid || awvalid) && !ls_q) begin
				ls_q <= 1'b1;
				li_q <= arvalid ? arid : awid;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_lock_legal: assert property ((arvalid |-> arlock != LOCK_RSVD) and (awvalid |-> awlock != LOCK_RSVD))
		else $error("reserved lock code issued");
	a_refuse_quiet: assert property (cmd_valid && cmd_ready && cmd_lock == LOCK_RSVD
		|=> rsp_valid && rsp_refused && !arvalid && !awvalid) else $error("reserved command reached bus");
	a_idle_clear: assert property (cmd_ready |-> !(arvalid || awvalid || wvalid || rready || bready))
		else $error("transaction outstanding while idle");
	a_one_dir: assert property (awvalid || wvalid || bready |-> !(arvalid || rready))
		else $error("write overlaps read");
	a_excl_aligned: assert property (arvalid && arlock == LOCK_EXCL
		|-> (araddr & ~({ADDR_W{1'b1}} << arsize)) == '0) else $error("exclusive read misaligned");
	a_excl_uncached: assert property ((arvalid && arlock == LOCK_EXCL |-> !arcache[1])
		and (awvalid && awlock == LOCK_EXCL |-> !awcache[1])) else $error("exclusive access cacheable");
	a_single_beat: assert property ((awvalid |-> awlen == LEN_SINGLE) and (wvalid |-> wlast)
		and (arvalid |-> arlen == LEN_SINGLE)) else $error("burst longer than one beat");
	a_excl_match: assert property (awvalid && awlock == LOCK_EXCL
		|-> awaddr == ra_q && awid == ri_q && awsize == rs_q) else $error("exclusive write differs from read");
	a_excl_granted: assert property (awvalid && awlock == LOCK_EXCL |-> ok_q)
		else $error("exclusive write without granted read");
	a_lock_same_id: assert property (lock_active && ls_q && (arvalid || awvalid)
		|-> (arvalid ? arid : awid) == li_q) else $error("locked sequence ID changed");
	a_lock_release: assert property ($fell(lock_active) |-> rsp_valid || $past(rsp_valid))
		else $error("lock released without completion");

	c_excl_ok: cover property (rsp_valid && rsp_excl_ok);
	c_locked: cover property ($rose(lock_active));
	c_refused: cover property (rsp_valid && rsp_refused);
endmodule : lock_chk

bind excl_lock_master lock_chk #(.ADDR_W(ADDR_W), .ID_W(ID_W)) u_chk (.*);

// ---- testbench/testbench.sv ----
// Self-checking bench for the atomic-access master.
// Assumes slave_model on the bus side and lock_chk bound in.
`timescale 1ns/1ps
module testbench
	import excl_lock_pkg::*;
();
	logic        mclk, resetn, cmd_valid, cmd_write, excl_en, stall;
	logic        cmd_ready, rsp_valid, rsp_excl_ok, rsp_refused, lock_active;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  cmd_lock, rsp_resp, awlock, arlock, bresp, rresp;
	logic [3:0]  cmd_id, awid, arid;
	logic [2:0]  cmd_size;
	logic [31:0] cmd_addr, cmd_wdata, rsp_rdata, awaddr, araddr, wdata, rdata;
	int          err_count, tests_run, cyc;

	excl_lock_master dut (.bid(4'h0), .rid(4'h0), .rlast(rvalid), .awlen(), .awsize(),
		.awburst(), .awcache(), .awprot(), .wid(), .wstrb(), .wlast(), .arlen(), .arsize(), .arburst(),
		.arcache(), .arprot(), .*);
	slave_model u_slv (.*);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic op(logic w, logic [1:0] lk, logic [31:0] a, logic [3:0] id, logic [31:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 60) begin
			@(posedge mclk);
			#1;
			n++;
		end
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_lock = lk;
		cmd_addr = a;
		cmd_id = id;
		cmd_wdata = d;
		@(posedge mclk);
		#1;
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 60) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("rsp_valid", 1, rsp_valid);
	endtask : op

	task automatic summarize();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_excl_ok();
		op(1, LOCK_NORMAL, 'h10, 2, 'h11);
		op(0, LOCK_EXCL, 'h10, 3, 0);
		chk("rd resp", RESP_EXOKAY, rsp_resp);
		chk("rd data", 'h11, rsp_rdata);
		op(1, LOCK_EXCL, 'h10, 3, 'h22);
		chk("wr resp", RESP_EXOKAY, rsp_resp);
		chk("excl_ok", 1, rsp_excl_ok);
		op(0, LOCK_NORMAL, 'h10, 3, 0);
		chk("mem", 'h22, rsp_rdata);
	endtask : t_excl_ok

	task automatic t_excl_fail();
		op(0, LOCK_EXCL, 'h20, 3, 0);
		op(1, LOCK_NORMAL, 'h20, 4, 'h33);
		op(1, LOCK_EXCL, 'h20, 3, 'h44);
		chk("wr resp", RESP_OKAY, rsp_resp);
		chk("excl_ok", 0, rsp_excl_ok);
		op(0, LOCK_NORMAL, 'h20, 3, 0);
		chk("mem", 'h33, rsp_rdata);
	endtask : t_excl_fail

	task automatic t_replace();
		op(0, LOCK_EXCL, 'h30, 5, 0);
		op(0, LOCK_EXCL, 'h34, 5, 0);
		op(1, LOCK_EXCL, 'h34, 5, 'h55);
		chk("wr resp", RESP_EXOKAY, rsp_resp);
	endtask : t_replace

	task automatic t_unsup();
		excl_en = 1'b0;
		op(0, LOCK_EXCL, 'h10, 3, 0);
		chk("rd resp", RESP_OKAY, rsp_resp);
		op(1, LOCK_EXCL, 'h10, 3, 'h66);
		chk("refused", 1, rsp_refused);
		op(0, LOCK_NORMAL, 'h10, 3, 0);
		chk("mem", 'h22, rsp_rdata);
		excl_en = 1'b1;
	endtask : t_unsup

	task automatic t_refuse();
		op(0, LOCK_RSVD, 'h10, 1, 0);
		chk("refused", 1, rsp_refused);
		chk("resp", RESP_OKAY, rsp_resp);
		op(0, LOCK_EXCL, 'h12, 1, 0);
		chk("refused", 1, rsp_refused);
		op(0, LOCK_EXCL, 'h10, 1, 0);
		op(1, LOCK_EXCL, 'h14, 1, 0);
		chk("refused", 1, rsp_refused);
		op(1, LOCK_EXCL, 'h10, 2, 0);
		chk("refused", 1, rsp_refused);
		cmd_size = 3'h1;
		op(1, LOCK_EXCL, 'h10, 1, 0);
		chk("refused", 1, rsp_refused);
		cmd_size = 3'h2;
	endtask : t_refuse

	task automatic t_locked();
		op(0, LOCK_LOCKED, 'h10, 6, 0);
		chk("lock_active", 1, lock_active);
		op(1, LOCK_NORMAL, 'h14, 9, 'h77);
		chk("lock_active", 1, lock_active);
		@(posedge mclk);
		#1;
		chk("lock_active", 0, lock_active);
		stall = 1'b1;
		fork
			op(0, LOCK_NORMAL, 'h14, 1, 0);
			begin
				repeat (6) @(posedge mclk);
				#1 stall = 1'b0;
			end
		join
		chk("slow rd", 'h77, rsp_rdata);
	endtask : t_locked

	task automatic t_reset();
		op(0, LOCK_EXCL, 'h10, 7, 0);
		resetn = 1'b0;
		repeat (2) @(posedge mclk);
		#1 resetn = 1'b1;
		chk("cmd_ready", 1, cmd_ready);
		op(1, LOCK_EXCL, 'h10, 7, 'h88);
		chk("refused", 1, rsp_refused);
	endtask : t_reset

	initial begin
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_lock = 2'h0;
		cmd_addr = 32'h0;
		cmd_id = 4'h0;
		cmd_size = 3'h2;
		cmd_wdata = 32'h0;
		excl_en = 1'b1;
		stall = 1'b0;
		err_count = 0;
		tests_run = 0;
		cyc = 0;
		repeat (4) @(posedge mclk);
		#1 resetn = 1'b1;
		chk("cmd_ready", 1, cmd_ready);
		chk("lock_active", 0, lock_active);
		op(1, LOCK_EXCL, 'h40, 1, 'h5);
		chk("refused", 1, rsp_refused);
		t_excl_ok();
		t_excl_fail();
		t_replace();
		t_unsup();
		t_refuse();
		t_locked();
		t_reset();
		summarize();
	end
endmodule : testbench
